// File: rtl/tta_pkg.sv
/*
  constants and types for the teach threshold alarm unit.
  assumes a 200 MHz core clock and features delivered as unsigned words.
*/
package tta_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned HOLD_MS          = 3000;
  localparam int unsigned HOLD_CYC         = HOLD_MS * 1000 * CLK_MHZ;
  localparam int unsigned FEAT_W           = 16;
  localparam int unsigned NFEAT            = 4;
  localparam int unsigned SEL_W            = 2;
  localparam logic [7:0]  SENS_MIN         = 8'h14;
  localparam logic [7:0]  SENS_MAX         = 8'hC8;
  localparam logic [7:0]  SENS_DEF         = 8'h50;
  localparam logic [7:0]  PCT_FULL         = 8'h64;
  localparam logic [10:0] CYC_MIN          = 11'h001;
  localparam logic [10:0] CYC_MAX          = 11'h7D0;
  localparam int unsigned CYC_UNIT_MS      = 50;
  localparam int unsigned CYC_UNIT_CLK     = CYC_UNIT_MS * 1000 * CLK_MHZ;
  localparam logic [FEAT_W-1:0] SIG_MARGIN = 16'h0010;
  localparam logic [2:0]  LED_GREEN        = 3'h1;
  localparam logic [2:0]  LED_YELLOW       = 3'h2;
  localparam logic [2:0]  LED_RED          = 3'h4;
  localparam logic [2:0]  LED_OFF          = 3'h0;

  typedef enum logic [2:0] {
    TTA_IDLE,
    TTA_NORMAL,
    TTA_ABNORMAL,
    TTA_CALC,
    TTA_MONITOR
  } tta_state_t;
endpackage

// File: rtl/tta_key_hold.sv
/*
  key hold detector: synchronises a key pin and pulses once per hold.
  assumes the key is an asynchronous, active high pin.
*/
`timescale 1ns/1ps
module tta_key_hold #(
  parameter int unsigned HOLD = 600000000
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  // key pin and arm
  input  wire logic i_key,
  input  wire logic i_arm,
  // pulse after full hold
  output logic      o_held
);
  logic [1:0]  sync_q;   // two-flop synchroniser
  logic [31:0] cnt_q;    // hold time counter
  logic        done_q;   // one pulse per press

  // synchroniser: second flop only is read
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      sync_q <= 2'h0;
    else
      sync_q <= {sync_q[0], i_key};
  end

  // count while held and armed; release restarts
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || !sync_q[1] || !i_arm)
    begin
      cnt_q  <= 32'h0;
      done_q <= 1'b0;
    end
    else if (!done_q && cnt_q == HOLD - 1)
      done_q <= 1'b1;
    else if (!done_q)
      cnt_q <= cnt_q + 32'h1;
  end

  // pulse exactly once when the hold completes
  assign o_held = sync_q[1] && i_arm && !done_q && cnt_q == HOLD - 1;
endmodule

// File: rtl/tta_alarm.sv
/*
  teach threshold alarm unit: teaching sequence, threshold derivation and
  the monitoring comparators driving the status lamp and alarm outputs.
  assumes features arrive with a same-clock valid strobe per calc cycle.
*/
`timescale 1ns/1ps
module tta_alarm
  import tta_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = tta_pkg::HOLD_CYC,
  parameter int unsigned UNIT_CYCLES = tta_pkg::CYC_UNIT_CLK
) (
  // clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_sys_rst,
  // front panel keys (pins)
  input  wire logic                        i_key_normal,
  input  wire logic                        i_key_abnormal,
  input  wire logic                        i_monitor_level_shown,
  // configuration
  input  wire logic [7:0]                  i_sensitivity,
  input  wire logic                        i_lower_limit,
  input  wire logic [10:0]                 i_feature_cycle_setting,
  input  wire logic                        i_warn_wr,
  input  wire logic [tta_pkg::FEAT_W-1:0]  i_warn_val,
  input  wire logic                        i_crit_wr,
  input  wire logic [tta_pkg::FEAT_W-1:0]  i_crit_val,
  // feature stream
  input  wire logic                        i_feat_valid,
  input  wire logic [tta_pkg::FEAT_W*tta_pkg::NFEAT-1:0] i_feat,
  // indicators and alarm outputs
  output logic                             o_teaching_indicator,
  output logic                             o_teach_success_indicator,
  output logic [2:0]                       o_status_led,
  output logic                             o_alarm_out1,
  output logic                             o_alarm_out2,
  output logic [tta_pkg::SEL_W-1:0]        o_feat_sel,
  output logic [tta_pkg::FEAT_W-1:0]       o_warn_thr,
  output logic [tta_pkg::FEAT_W-1:0]       o_crit_thr
);
  import tta_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  tta_state_t        state_q;           // teaching sequencer
  logic              start_hold;        // normal key held long enough
  logic              end_hold;          // abnormal key held long enough
  logic [7:0]        sens_eff;          // clamped sensitivity
  logic [10:0]       fcyc_eff;          // clamped feature cycle setting
  logic [31:0]       win_cnt_q;         // normal-capture window clock
  logic [10:0]       win_units_q;       // elapsed 50 ms units
  logic              win_done;          // normal window over
  logic [FEAT_W-1:0] nmax_q [NFEAT];    // normal maxima
  logic [FEAT_W-1:0] amax_q [NFEAT];    // abnormal maxima
  logic              ngot_q;            // at least one normal sample
  logic              agot_q;            // at least one abnormal sample
  logic [SEL_W-1:0]  best_sel;          // most changed feature
  logic [FEAT_W-1:0] best_diff;         // its change
  logic [FEAT_W+7:0] scaled;            // abnormal maximum times sensitivity
  logic [FEAT_W-1:0] thr_calc;          // derived threshold
  logic              teach_ok;          // abnormal capture significant
  logic [FEAT_W-1:0] cur;               // monitored feature sample
  logic              warn_hit;          // warning judgment
  logic              crit_hit;          // critical judgment

  ////////////////////////////////////////////////////////////////////////
  // key hold detectors, armed only where each key has meaning
  tta_key_hold #(.HOLD(HOLD_CYCLES)) u_key_norm (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_key      (i_key_normal),
    .i_arm      (i_monitor_level_shown &&
                 (state_q == TTA_IDLE || state_q == TTA_MONITOR)),
    .o_held     (start_hold)
  );

  tta_key_hold #(.HOLD(HOLD_CYCLES)) u_key_abn (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_key      (i_key_abnormal),
    .i_arm      (state_q == TTA_ABNORMAL),
    .o_held     (end_hold)
  );

  ////////////////////////////////////////////////////////////////////////
  // out-of-range settings are clamped rather than rejected
  always_comb
  begin
    sens_eff = i_sensitivity;
    if (i_sensitivity < SENS_MIN)
      sens_eff = SENS_MIN;
    else if (i_sensitivity > SENS_MAX)
      sens_eff = SENS_MAX;
    fcyc_eff = i_feature_cycle_setting;
    if (i_feature_cycle_setting < CYC_MIN)
      fcyc_eff = CYC_MIN;
    else if (i_feature_cycle_setting > CYC_MAX)
      fcyc_eff = CYC_MAX;
  end

  ////////////////////////////////////////////////////////////////////////
  // normal-capture window: setting times 50 ms of clock
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || state_q != TTA_NORMAL)
    begin
      win_cnt_q   <= 32'h0;
      win_units_q <= 11'h0;
    end
    else if (win_cnt_q == UNIT_CYCLES - 1)
    begin
      win_cnt_q   <= 32'h0;
      win_units_q <= win_units_q + 11'h1;
    end
    else
      win_cnt_q <= win_cnt_q + 32'h1;
  end
  assign win_done = (win_units_q >= fcyc_eff);

  ////////////////////////////////////////////////////////////////////////
  // per-feature maxima of normal and abnormal data
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || start_hold)
    begin
      for (int k = 0; k < NFEAT; k++)
      begin
        nmax_q[k] <= '0;
        amax_q[k] <= '0;
      end
      ngot_q <= 1'b0;
      agot_q <= 1'b0;
    end
    else if (i_feat_valid && state_q == TTA_NORMAL)
    begin
      ngot_q <= 1'b1;
      for (int k = 0; k < NFEAT; k++)
        if (i_feat[k*FEAT_W +: FEAT_W] > nmax_q[k])
          nmax_q[k] <= i_feat[k*FEAT_W +: FEAT_W];
    end
    else if (i_feat_valid && state_q == TTA_ABNORMAL)
    begin
      agot_q <= 1'b1;
      for (int k = 0; k < NFEAT; k++)
        if (i_feat[k*FEAT_W +: FEAT_W] > amax_q[k])
          amax_q[k] <= i_feat[k*FEAT_W +: FEAT_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // feature with the largest change between the two sets
  always_comb
  begin
    logic [FEAT_W-1:0] d;
    d         = '0;
    best_sel  = '0;
    best_diff = '0;
    for (int k = 0; k < NFEAT; k++)
    begin
      d = (amax_q[k] > nmax_q[k]) ? amax_q[k] - nmax_q[k]
                                  : nmax_q[k] - amax_q[k];
      if (d > best_diff)
      begin
        best_diff = d;
        best_sel  = SEL_W'(k);
      end
    end
  end

  // threshold = abnormal maximum times sensitivity / 100
  assign scaled   = amax_q[best_sel] * sens_eff;
  assign thr_calc = FEAT_W'(scaled / PCT_FULL);
  assign teach_ok = agot_q && best_diff >= SIG_MARGIN;

  ////////////////////////////////////////////////////////////////////////
  // teaching sequencer
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      state_q <= TTA_IDLE;
    else
      case (state_q)
        TTA_IDLE, TTA_MONITOR:
          if (start_hold)
            state_q <= TTA_NORMAL;
        TTA_NORMAL:
          if (win_done)
            state_q <= ngot_q ? TTA_ABNORMAL : TTA_IDLE;
        TTA_ABNORMAL:
          if (end_hold)
            state_q <= TTA_CALC;
        TTA_CALC:
          state_q <= teach_ok ? TTA_MONITOR : TTA_IDLE;
        default:
          state_q <= TTA_IDLE;
      endcase
  end

  // indicators follow the sequencer
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_teaching_indicator      <= 1'b0;
      o_teach_success_indicator <= 1'b0;
    end
    else if (start_hold)
    begin
      o_teaching_indicator      <= 1'b0;
      o_teach_success_indicator <= 1'b0;
    end
    else if (state_q == TTA_NORMAL && win_done)
      o_teaching_indicator <= ngot_q;
    else if (state_q == TTA_CALC)
    begin
      o_teaching_indicator      <= 1'b0;
      o_teach_success_indicator <= teach_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // thresholds: equal at teaching end, separately writable after
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_warn_thr <= '0;
      o_crit_thr <= '0;
      o_feat_sel <= '0;
    end
    else if (state_q == TTA_CALC && teach_ok)
    begin
      o_warn_thr <= thr_calc;
      o_crit_thr <= thr_calc;
      o_feat_sel <= best_sel;
    end
    else
    begin
      if (i_warn_wr)
        o_warn_thr <= i_warn_val;
      if (i_crit_wr)
        o_crit_thr <= i_crit_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // judgments and outputs
  assign cur = i_feat[o_feat_sel*FEAT_W +: FEAT_W];
  assign warn_hit = i_lower_limit ? (cur < o_warn_thr)
                                  : (cur > o_warn_thr);
  assign crit_hit = i_lower_limit ? (cur < o_crit_thr)
                                  : (cur > o_crit_thr);

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || state_q != TTA_MONITOR)
    begin
      o_alarm_out1 <= 1'b0;
      o_alarm_out2 <= 1'b0;
      o_status_led <= LED_OFF;
    end
    else if (i_feat_valid)
    begin
      o_alarm_out1 <= crit_hit;
      o_alarm_out2 <= warn_hit;
      o_status_led <= crit_hit ? LED_RED :
                      warn_hit ? LED_YELLOW : LED_GREEN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_out1_red: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_alarm_out1 |-> o_status_led == LED_RED)
    else $error("alarm out1 without red lamp");
  chk_no_alarm_early: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    state_q != TTA_MONITOR |=> !o_alarm_out1 && !o_alarm_out2)
    else $error("alarm outside monitoring");
  chk_thr_equal: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_q == TTA_CALC && teach_ok |=> o_warn_thr == o_crit_thr)
    else $error("thresholds differ after teaching");
  chk_start_hold: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    state_q == TTA_IDLE && $past(state_q) == TTA_IDLE ##1
    state_q == TTA_NORMAL |-> $past(start_hold))
    else $error("teaching started without hold");
  chk_end_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    end_hold && state_q == TTA_ABNORMAL |=> state_q == TTA_CALC)
    else $error("abnormal hold did not end teaching");
  chk_success_lamp: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    state_q == TTA_CALC && teach_ok |=>
    o_teach_success_indicator && !o_teaching_indicator)
    else $error("success lamps wrong");
  chk_lamp_fail: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_q == TTA_NORMAL && win_done && !ngot_q |=>
    !o_teaching_indicator && state_q == TTA_IDLE)
    else $error("teaching lamp lit on failed capture");
  chk_direct_abn: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    state_q == TTA_NORMAL && win_done && ngot_q |=>
    state_q == TTA_ABNORMAL && o_teaching_indicator)
    else $error("abnormal capture did not follow");
  chk_warn_pol: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_q == TTA_MONITOR && i_feat_valid && warn_hit |=> o_alarm_out2)
    else $error("warning not raised");
  chk_thr_scale: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    state_q == TTA_CALC && teach_ok |=>
    o_crit_thr == FEAT_W'(((FEAT_W+8)'($past(amax_q[best_sel])) *
                           $past(sens_eff)) / PCT_FULL))
    else $error("threshold not scaled by sensitivity");

  cov_teach_done: cover property (@(posedge i_core_clk)
    state_q == TTA_CALC ##1 state_q == TTA_MONITOR);
  cov_warn: cover property (@(posedge i_core_clk) o_alarm_out2 && !o_alarm_out1);
  cov_crit: cover property (@(posedge i_core_clk) o_alarm_out1);
  cov_fail: cover property (@(posedge i_core_clk)
    state_q == TTA_NORMAL ##1 state_q == TTA_IDLE);
endmodule

// File: verif/tta_operator.sv
/*
  operator model: works the two front panel keys of the alarm unit.
  assumes keys are active high pins, sampled on the core clock.
*/
`timescale 1ns/1ps
module tta_operator #(
  parameter int unsigned HOLD = 20
) (
  // clock
  input  wire logic i_core_clk,
  // key pins
  output logic      o_key_normal,
  output logic      o_key_abnormal
);
  //////////////////////////////////////////////////////////////////////////
  // keys rest released, pin idles low
  initial
  begin
    o_key_normal   = 1'b0;
    o_key_abnormal = 1'b0;
  end

  // press one key for HOLD plus extra cycles, then let go
  // extra covers the pin sync delay; a negative extra gives a short press
  task automatic hold_key(input logic which, input int extra);
    @(posedge i_core_clk);
    if (which)
      o_key_abnormal <= 1'b1;
    else
      o_key_normal <= 1'b1;
    repeat (int'(HOLD) + extra) @(posedge i_core_clk);
    o_key_normal   <= 1'b0;
    o_key_abnormal <= 1'b0;
  endtask
endmodule

// File: verif/teach_threshold_alarm_unit_test.sv
/*
  self-checking bench for the teach threshold alarm unit.
  assumes tta_pkg, tta_alarm and tta_operator are compiled before it.
*/
`timescale 1ns/1ps
module teach_threshold_alarm_unit_test;
  import tta_pkg::*;
  localparam int unsigned HOLD = 20;  // shortened key hold
  localparam int unsigned UNIT = 5;   // shortened 50 ms unit
  typedef struct {string name; int code; logic [15:0] exp;} tta_note_t;

  logic        i_core_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        key_normal, key_abnormal, teach_lamp, ok_lamp, out1, out2;
  logic        shown = 1'b1;       // monitoring level on display
  logic [7:0]  sens = SENS_DEF;
  logic [10:0] fcyc = 11'h002;     // feature cycle setting, 50 ms units
  logic        lower = 1'b0;
  logic        warn_wr = 1'b0, crit_wr = 1'b0;
  logic [15:0] warn_val = 16'h0000, crit_val = 16'h0000;
  logic        feat_valid = 1'b0;
  logic        feat_on = 1'b1;     // stream gate, off starves teaching
  logic [63:0] feat = '0;
  logic [15:0] feat2 = 16'h0100;   // value of the feature that changes
  logic [15:0] side [64];          // random band for the other features
  logic [5:0]  idx = 6'h00;
  logic [1:0]  cnt = 2'h0;
  logic [2:0]  led;
  logic [1:0]  sel;
  logic [15:0] warn_thr, crit_thr;
  int          num_errors = 0;
  int          tests_run = 0;
  tta_note_t   notes [$];          // expected results, oldest first

  always #2.5 i_core_clk = ~i_core_clk;

  //////////////////////////////////////////////////////////////////////////
  tta_operator #(.HOLD(HOLD)) op (
    .i_core_clk     (i_core_clk),
    .o_key_normal   (key_normal),
    .o_key_abnormal (key_abnormal)
  );

  tta_alarm #(.HOLD_CYCLES(HOLD), .UNIT_CYCLES(UNIT)) dut (
    .i_core_clk                (i_core_clk),
    .i_sys_rst                 (i_sys_rst),
    .i_key_normal              (key_normal),
    .i_key_abnormal            (key_abnormal),
    .i_monitor_level_shown     (shown),
    .i_sensitivity             (sens),
    .i_lower_limit             (lower),
    .i_feature_cycle_setting   (fcyc),
    .i_warn_wr                 (warn_wr),
    .i_warn_val                (warn_val),
    .i_crit_wr                 (crit_wr),
    .i_crit_val                (crit_val),
    .i_feat_valid              (feat_valid),
    .i_feat                    (feat),
    .o_teaching_indicator      (teach_lamp),
    .o_teach_success_indicator (ok_lamp),
    .o_status_led              (led),
    .o_alarm_out1              (out1),
    .o_alarm_out2              (out2),
    .o_feat_sel                (sel),
    .o_warn_thr                (warn_thr),
    .o_crit_thr                (crit_thr)
  );

  //////////////////////////////////////////////////////////////////////////
  // one sample every fourth cycle; only feature 2 carries the fault
  always @(posedge i_core_clk)
  begin
    cnt        <= cnt + 2'h1;
    idx        <= idx + 6'h01;
    feat_valid <= feat_on && (cnt == 2'h3);
    feat       <= {side[idx], feat2, side[~idx], side[idx]};
  end

  // observed value of each checked output, widened to 16 bits
  function automatic logic [15:0] seen(input int code);
    case (code)
      0: seen = {15'h0000, teach_lamp};
      1: seen = {15'h0000, ok_lamp};
      2: seen = {13'h0000, led};
      3: seen = {15'h0000, out1};
      4: seen = {15'h0000, out2};
      5: seen = {14'h0000, sel};
      6: seen = warn_thr;
      default: seen = crit_thr;
    endcase
  endfunction

  // watcher: outputs are settled at the falling edge
  always @(negedge i_core_clk)
  begin
    tta_note_t n;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      tests_run++;
      if (seen(n.code) !== n.exp)
      begin
        num_errors++;
        $display("[FAIL] %s expected %h seen %h", n.name, n.exp,
                 seen(n.code));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic note_exp(input string nm, input int c, input logic [15:0] e);
    notes.push_back('{nm, c, e});
  endtask

  // set polarity and feature, wait past two samples, note the outputs
  task automatic mon(input logic lo, input logic [15:0] f,
                     input logic [2:0] l, input logic a1, input logic a2);
    lower <= lo;
    feat2 <= f;
    repeat (10) @(posedge i_core_clk);
    note_exp("status_led", 2, {13'h0000, l});
    note_exp("alarm_out1", 3, {15'h0000, a1});
    note_exp("alarm_out2", 4, {15'h0000, a2});
  endtask

  // one-cycle threshold write, warning or critical
  task automatic wr_thr(input logic crit, input logic [15:0] v);
    @(posedge i_core_clk);
    warn_wr  <= ~crit;
    crit_wr  <= crit;
    warn_val <= v;
    crit_val <= v;
    @(posedge i_core_clk);
    warn_wr  <= 1'b0;
    crit_wr  <= 1'b0;
  endtask

  // full teaching run; sensitivity s1 is the one in force at the end
  task automatic teach(input logic [7:0] s0, input logic [7:0] s1,
                       input logic [15:0] thr);
    sens  <= s0;
    feat2 <= 16'h0100;
    repeat (8) @(posedge i_core_clk);
    op.hold_key(1'b0, 6);
    repeat (20) @(posedge i_core_clk);
    note_exp("teaching_indicator", 0, 16'h0001);
    note_exp("teach_success_indicator", 1, 16'h0000);
    feat2 <= 16'h07D0;
    repeat (12) @(posedge i_core_clk);
    sens <= s1;
    op.hold_key(1'b1, 6);
    repeat (6) @(posedge i_core_clk);
    note_exp("teaching_indicator", 0, 16'h0000);
    note_exp("teach_success_indicator", 1, 16'h0001);
    note_exp("feat_sel", 5, 16'h0002);
    note_exp("warn_thr", 6, thr);
    note_exp("crit_thr", 7, thr);
    feat2 <= 16'h0100;
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the roughly 520 cycles of the tests
  initial
  begin
    repeat (6000) @(posedge i_core_clk);
    num_errors++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h7EAB));
    foreach (side[i])
      side[i] = 16'h0100 + 16'($urandom % 128);
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    mon(1'b0, 16'hFFFF, LED_OFF, 1'b0, 1'b0);
    // starved window: teaching lamp stays dark, still no monitoring
    feat_on <= 1'b0;
    op.hold_key(1'b0, 6);
    repeat (20) @(posedge i_core_clk);
    note_exp("teaching_indicator", 0, 16'h0000);
    feat_on <= 1'b1;
    mon(1'b0, 16'hFFFF, LED_OFF, 1'b0, 1'b0);
    teach(SENS_DEF, SENS_DEF, 16'h0640);
    mon(1'b0, 16'h0100, LED_GREEN, 1'b0, 1'b0);
    mon(1'b0, 16'h0700, LED_RED, 1'b1, 1'b1);
    wr_thr(1'b0, 16'h0300);
    wr_thr(1'b1, 16'h0350);
    note_exp("warn_thr", 6, 16'h0300);
    note_exp("crit_thr", 7, 16'h0350);
    mon(1'b0, 16'h0300, LED_GREEN, 1'b0, 1'b0);
    mon(1'b0, 16'h0320, LED_YELLOW, 1'b0, 1'b1);
    mon(1'b0, 16'h0400, LED_RED, 1'b1, 1'b1);
    mon(1'b1, 16'h0320, LED_RED, 1'b1, 1'b0);
    mon(1'b1, 16'h0200, LED_RED, 1'b1, 1'b1);
    mon(1'b1, 16'h0400, LED_GREEN, 1'b0, 1'b0);
    mon(1'b0, 16'h0100, LED_GREEN, 1'b0, 1'b0);
    // refused starts: level not shown, then a press cut short
    shown <= 1'b0;
    op.hold_key(1'b0, 6);
    shown <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    note_exp("teach_success_indicator", 1, 16'h0001);
    op.hold_key(1'b0, -4);
    repeat (4) @(posedge i_core_clk);
    note_exp("teach_success_indicator", 1, 16'h0001);
    // zero cycle setting must clamp to one unit, else the window is empty
    fcyc <= 11'h000;
    teach(SENS_MAX, 8'hFF, 16'h0FA0);
    teach(SENS_MAX, SENS_MIN, 16'h0190);
    repeat (2) @(negedge i_core_clk);
    print_verdict();
  end
endmodule
